// >>> dv/tb_timer01_mode0_counter.sv
// Self-checking bench for the two basic timers
`timescale 1ns/1ps
`default_nettype none
module tb_timer01_mode0_counter
  import timer01_pkg::*;
;
  logic        clock_i, rst_i, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_o;
  logic        pready_o, pslverr_o, irq_o, t0_ovf_o, t1_ovf_o;
  logic        ar_high_ovf_o, adc_trig_o;
  logic [1:0]  irq_ack, seen;
  wire logic [1:0] ev, gt;
  wire logic [2:0] ar;
  wire logic [1:0] ovf = {t1_ovf_o, t0_ovf_o};
  int n_mismatch, checked, cyc;

  timer01_mode0_counter u_timer01_mode0_counter (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .event_pin_a_i(ev[0]), .event_pin_b_i(ev[1]),
    .gate_input_a_i(gt[0]), .gate_input_b_i(gt[1]), .irq_ack_i(irq_ack),
    .ar_full_ovf_i(ar[0]), .ar_hi_byte_ovf_i(ar[1]),
    .ar_lo_byte_ovf_i(ar[2]), .irq_o(irq_o), .t0_ovf_o(t0_ovf_o),
    .t1_ovf_o(t1_ovf_o), .ar_high_ovf_o(ar_high_ovf_o),
    .adc_trig_o(adc_trig_o));
  timer01_pins u_timer01_pins (
    .clock_i(clock_i), .event_o(ev), .gate_o(gt), .ar_o(ar));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(negedge clock_i) begin
    if (ar_high_ovf_o === 1'b1) seen[0] <= 1'b1;
    if (adc_trig_o === 1'b1) seen[1] <= 1'b1;
  end
  // Longest test waits three t0 wraps; the second is a full 8192 cycles, the third a little less
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clock_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    q = prdata_o;
    e = pslverr_o;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {24'h0, d}, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic wait_ovf(input int tm, output int n);
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (ovf[tm] !== 1'b1 && n < 20000);
  endtask : wait_ovf
  // ==========================================================
  // Tests
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    for (int a = 0; a <= 'h28; a += 4) begin
      rd(8'(a), q);
      chk(q, 32'h0);
    end
    apb(1'b0, 8'h2c, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mode0();
    logic [31:0] q, q2;
    int          n;
    wr(OFS_CLKCTL, 8'h0c);
    wr(OFS_T0_LOW, 8'hff);
    wr(OFS_T0_HIGH, 8'h00);
    wr(OFS_CTRL, 8'h10);
    rd(OFS_T0_HIGH, q);
    chk(q, 32'h1);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_T0_LOW, q);
    rd(OFS_T0_LOW, q2);
    chk(q2, q);
    wr(OFS_T0_LOW, 8'hf8);
    wr(OFS_T0_HIGH, 8'hff);
    seen = 2'h0;
    wr(OFS_CTRL, 8'h10);
    wait_ovf(0, n);
    wait_ovf(0, n);
    chk(n, 8192);
    chk(seen[1], 1'b1);
    chk(irq_o, 1'b0);
    rd(OFS_CTRL, q);
    chk(q[CTRL_FLAG0], 1'b1);
    wr(OFS_IRQ_EN, 8'h01);
    repeat (3) @(negedge clock_i);
    chk(irq_o, 1'b1);
    wr(OFS_IRQ_STAT, 8'h01);
    repeat (3) @(negedge clock_i);
    chk(irq_o, 1'b0);
    wr(OFS_CTRL, 8'h10);
    rd(OFS_CTRL, q);
    chk(q[CTRL_FLAG0], 1'b0);
    wait_ovf(0, n);
    @(posedge clock_i);
    irq_ack <= 2'h1;
    @(posedge clock_i);
    irq_ack <= 2'h0;
    rd(OFS_CTRL, q);
    chk(q[CTRL_FLAG0], 1'b0);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_IRQ_EN, 8'h00);
    $display("test mode0 done");
  endtask : t_mode0
  task automatic t_clock();
    int         r[5] = '{12, 4, 48, 8, 1};
    int         n;
    logic [7:0] b;
    for (int k = 0; k < 5; k++) begin
      b = (k % 2) ? OFS_T1_LOW : OFS_T0_LOW;
      wr(OFS_CLKCTL, (k == 4) ? 8'h04 : 8'(k));
      wr(b, 8'hf8);
      wr(b + 8'h04, 8'hff);
      wr(OFS_CTRL, (k % 2) ? 8'h40 : 8'h10);
      wait_ovf(k % 2, n);
      chk(n >= 7 * r[k] && n <= 8 * r[k] + 6, 1'b1);
      wr(OFS_CTRL, 8'h00);
    end
    $display("test clock done");
  endtask : t_clock
  task automatic t_event();
    logic [31:0] q;
    wr(OFS_MODE, 8'h44);
    for (int tm = 0; tm < 2; tm++) begin
      wr(8'(tm * 8), 8'h00);
      wr(8'(tm * 8 + 4), 8'h00);
    end
    wr(OFS_CTRL, 8'h50);
    for (int tm = 0; tm < 2; tm++) begin
      u_timer01_pins.pulse(tm, 5 - 2 * tm);
      repeat (8) @(negedge clock_i);
      rd(8'(tm * 8), q);
      chk(q & 32'h1f, 5 - 2 * tm);
    end
    wr(OFS_CTRL, 8'h00);
    $display("test event done");
  endtask : t_event
  task automatic t_gate();
    logic [31:0] q, q2;
    wr(OFS_CLKCTL, 8'h0c);
    wr(OFS_MODE, 8'h88);
    wr(OFS_CTRL, 8'h50);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_PINCFG, i[1] ? (i[2] ? 8'h80 : 8'h08) : 8'h00);
      u_timer01_pins.set_gate(i[2], i[0]);
      repeat (6) @(negedge clock_i);
      rd(i[2] ? OFS_T1_LOW : OFS_T0_LOW, q);
      rd(i[2] ? OFS_T1_LOW : OFS_T0_LOW, q2);
      chk(q != q2, i[0] != i[1]);
    end
    wr(OFS_CTRL, 8'h00);
    $display("test gate done");
  endtask : t_gate
  task automatic t_modes();
    logic [31:0] q, q2;
    int          n;
    wr(OFS_CLKCTL, 8'h0c);
    wr(OFS_MODE, 8'h21);
    wr(OFS_T0_LOW, 8'hff);
    wr(OFS_T0_HIGH, 8'hff);
    wr(OFS_T1_LOW, 8'hfe);
    wr(OFS_T1_HIGH, 8'h80);
    wr(OFS_CTRL, 8'h50);
    wait_ovf(0, n);
    wait_ovf(1, n);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_T0_LOW, q);
    chk(q[7:5], 3'h0);
    rd(OFS_T1_HIGH, q);
    chk(q, 32'h80);
    rd(OFS_T1_LOW, q);
    chk(q[7], 1'b1);
    wr(OFS_MODE, 8'h33);
    wr(OFS_CTRL, 8'h50);
    rd(OFS_T0_LOW, q);
    rd(OFS_T0_LOW, q2);
    chk(q2, q);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_MODE, 8'h00);
    $display("test modes done");
  endtask : t_modes
  task automatic t_route();
    logic [1:0] e;
    for (int i = 0; i < 12; i++) begin
      int l, w;
      l = i / 3;
      w = i % 3;
      wr(OFS_LINKCFG, 8'(l));
      seen = 2'h0;
      u_timer01_pins.fire(w);
      repeat (3) @(negedge clock_i);
      e[0] = l[0] ? w == 1 : w == 0;
      e[1] = l[1] && (l[0] ? w == 2 : w == 0);
      chk(seen[0], e[0]);
      chk(seen[1], e[1]);
    end
    $display("test route done");
  endtask : t_route
  // ==========================================================
  // Main sequence
  initial begin
    rst_i   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    irq_ack = 2'h0;
    seen    = 2'h0;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_mode0();
    t_clock();
    t_event();
    t_gate();
    t_modes();
    t_route();
    report_and_stop();
  end
endmodule : tb_timer01_mode0_counter
`default_nettype wire

// >>> dv/timer01_monitor.sv
// Port checker for the two basic timers
`timescale 1ns/1ps
`default_nettype none
module timer01_monitor (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        ar_full_ovf_i,
  input wire logic        ar_hi_byte_ovf_i,
  input wire logic        irq_o,
  input wire logic        t0_ovf_o,
  input wire logic        t1_ovf_o,
  input wire logic        ar_high_ovf_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic setup, wr_done, unmapped;
  assign setup    = psel_i && !penable_i;
  assign wr_done  = psel_i && penable_i && pwrite_i && pready_o;
  assign unmapped = paddr_i > 8'h28 || paddr_i[1:0] != 2'h0;
  // ==========================================================
  // Bus answer
  setup_ready_a: assert property (setup |=> pready_o)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready_o |-> $past(setup))
    else $error("ready without setup");
  mapped_ok_a: assert property (setup && !unmapped |=> !pslverr_o)
    else $error("error on mapped address");
  unmapped_err_a: assert property (setup && unmapped |=>
    pslverr_o && prdata_o == 32'h0) else $error("unmapped not refused");
  // ==========================================================
  // Events
  high_route_a: assert property (ar_high_ovf_o |->
    $past(ar_full_ovf_i || ar_hi_byte_ovf_i)) else $error("stray high");
  t0_pulse_a: assert property (t0_ovf_o |=> !t0_ovf_o)
    else $error("t0 overflow pulse too long");
  t1_pulse_a: assert property (t1_ovf_o |=> !t1_ovf_o)
    else $error("t1 overflow pulse too long");
  // Interrupt may rise only after an overflow or a register write
  irq_cause_a: assert property ($rose(irq_o) |->
    $past(t0_ovf_o || t1_ovf_o) || $past(t0_ovf_o || t1_ovf_o, 2) ||
    $past(wr_done, 2) || $past(wr_done, 3)) else $error("stray irq");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |->
    !irq_o && !pready_o && !t0_ovf_o && !t1_ovf_o)
    else $error("outputs active in reset");
  cover property (t0_ovf_o);
  cover property (irq_o);
  cover property (pslverr_o);
  cover property (ar_high_ovf_o);
endmodule : timer01_monitor
bind timer01_mode0_counter timer01_monitor u_timer01_monitor (
  .clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .prdata_o, .pready_o, .pslverr_o, .ar_full_ovf_i, .ar_hi_byte_ovf_i,
  .irq_o, .t0_ovf_o, .t1_ovf_o, .ar_high_ovf_o);
`default_nettype wire

// >>> dv/timer01_pins.sv
// Model of the event, gate and auto-reload sources around the timers
`timescale 1ns/1ps
`default_nettype none
module timer01_pins (
  input  wire logic       clock_i,
  output var  logic [1:0] event_o,
  output var  logic [1:0] gate_o,
  output var  logic [2:0] ar_o
);
  initial begin
    event_o = 2'h3;
    gate_o  = 2'h0;
    ar_o    = 2'h0;
  end
  // Three clocks low keeps margin over the two-clock minimum; between pulses the high level lasts three clocks
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge clock_i);
      event_o[sel] <= 1'b0;
      repeat (3) @(posedge clock_i);
      event_o[sel] <= 1'b1;
      repeat (2) @(posedge clock_i);
    end
  endtask : pulse
  task automatic set_gate(input int sel, input logic v);
    @(posedge clock_i);
    gate_o[sel] <= v;
  endtask : set_gate
  task automatic fire(input int k);
    @(posedge clock_i);
    ar_o[k] <= 1'b1;
    @(posedge clock_i);
    ar_o[k] <= 1'b0;
  endtask : fire
endmodule : timer01_pins
`default_nettype wire

// >>> rtl/timer01_mode0_counter.sv
// Timer 0 and timer 1 with APB registers and overflow routing
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Offered high overflow is full overflow unsplit, high-byte overflow split
// - ADC trigger is timer 0 overflow, or with source bit set full overflow unsplit, low-byte overflow split
// - Each count is sixteen bits reached as separate low and high bytes
// - Own enable bit per timer gates its overflow interrupt
// - Each timer has its own two-bit mode field in shared register
// - Mode 0 count: high byte plus low byte bits four to zero
// - Low byte bits seven to five are undefined; software ignores them
// - Wrap from all ones to zero sets the overflow flag
// - One step per selected clock; period is 8192 minus start value
// - Counter select one: each sampled falling event-pin edge counts
// - Counter select zero: system clock if clock select set, else prescaled
// - Run zero stops; run one with gate zero always counts
// - Run and gate one: count only while gate input differs from polarity
// - Second timer behaves the same with its own control bits
// - Setting run leaves the count untouched
// - Second timer gated by its own input and own polarity bit
module timer01_mode0_counter
  import timer01_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  input  wire logic        event_pin_a_i,
  input  wire logic        event_pin_b_i,
  input  wire logic        gate_input_a_i,
  input  wire logic        gate_input_b_i,
  input  wire logic [1:0]  irq_ack_i,
  input  wire logic        ar_full_ovf_i,
  input  wire logic        ar_hi_byte_ovf_i,
  input  wire logic        ar_lo_byte_ovf_i,
  output var  logic        irq_o,
  output var  logic        t0_ovf_o,
  output var  logic        t1_ovf_o,
  output var  logic        ar_high_ovf_o,
  output var  logic        adc_trig_o
);
  // ==========================================================
  // Register state
  logic [1:0]  run_r,     run_nxt;
  logic [1:0]  flag_r,    flag_nxt;
  logic [7:0]  mode_r,    mode_nxt;
  logic [7:0]  clkctl_r,  clkctl_nxt;
  logic [7:0]  pincfg_r,  pincfg_nxt;
  logic [1:0]  irq_en_r,  irq_en_nxt;
  logic [1:0]  stat_r,    stat_nxt;
  logic [1:0]  link_r,    link_nxt;
  logic [31:0] rdata_nxt;
  logic        ready_nxt;
  logic        err_nxt;
  logic        irq_nxt;
  logic        wr_en;
  logic        setup;

  // ==========================================================
  // Pin synchronisers and clean levels
  logic [3:0]  pin_raw;
  logic [3:0]  sync1_r, sync2_r, sync3_r;
  logic [3:0]  level_r, level_nxt;
  logic [1:0]  fall_ev;

  // ==========================================================
  // Timer wiring
  timer_cfg_t  cfg     [2];
  logic [1:0]  step;
  logic [1:0]  go;
  logic [1:0]  wr_low, wr_high;
  logic [1:0]  ovf;
  logic [7:0]  cnt_low [2];
  logic [7:0]  cnt_high[2];
  logic [5:0]  presc_r, presc_nxt;
  logic [5:0]  div_sel;
  logic        presc_tick;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ==========================================================
  // Synchronisers: a level counts once stages two and three agree
  // Stage one may be metastable, so only stages two and three
  // are compared before a level is accepted
  assign pin_raw = {gate_input_b_i, gate_input_a_i,
                    event_pin_b_i, event_pin_a_i};

  always_comb begin
    level_nxt = level_r;
    for (int k = 0; k < 4; k++) begin
      if (sync2_r[k] == sync3_r[k]) begin
        level_nxt[k] = sync3_r[k];
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
      level_r <= 4'h0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      level_r <= level_nxt;
    end
  end

  // Reset leaves the clean levels low, so a pin that idles high
  // shows a rise after reset and never a false falling event
  // Falling edge of a clean event level
  assign fall_ev = level_r[1:0] & ~level_nxt[1:0];

  // ==========================================================
  // Prescaler shared by both timers
  // Free running: after a ratio change the first tick may come
  // early or late by up to one old period
  always_comb begin
    case (clkctl_r[1:0])
      2'h0:    div_sel = DIV_12;
      2'h1:    div_sel = DIV_4;
      2'h2:    div_sel = DIV_48;
      default: div_sel = DIV_8;
    endcase
    presc_tick = (presc_r >= div_sel - 6'h01);
    presc_nxt  = presc_tick ? 6'h00 : presc_r + 6'h01;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      presc_r <= 6'h00;
    end else begin
      presc_r <= presc_nxt;
    end
  end

  // ==========================================================
  // Per-timer run control, clock choice and counter
  assign cfg[0] = timer_cfg_t'(mode_r[3:0]);
  assign cfg[1] = timer_cfg_t'(mode_r[MODE_T1_LSB +: 4]);

  // Both timers share one prescaler, so their ticks stay in step
  generate
    for (genvar i = 0; i < 2; i++) begin : g_tmr
      logic pol;
      logic csel;
      logic gate_lvl;
      assign pol      = (i == 0) ? pincfg_r[POL_A] : pincfg_r[POL_B];
      assign csel     = (i == 0) ? clkctl_r[CLK_SEL0] : clkctl_r[CLK_SEL1];
      assign gate_lvl = level_r[2 + i];
      // Gate active while the pin differs from its polarity bit
      assign go[i] = run_r[i] &
                     (~cfg[i].gate | (gate_lvl != pol));
      assign step[i] = go[i] & (cfg[i].cnt_sel ? fall_ev[i]
                     : (csel ? 1'b1 : presc_tick));
      assign wr_low[i]  = wr_en & hit(paddr_i, OFS_T0_LOW  + 8'(8 * i));
      assign wr_high[i] = wr_en & hit(paddr_i, OFS_T0_HIGH + 8'(8 * i));

      timer01_unit u_unit (
        .clock_i      (clock_i),
        .rst_i        (rst_i),
        .step_i       (step[i]),
        .cfg_i        (cfg[i]),
        .wr_low_i     (wr_low[i]),
        .wr_high_i    (wr_high[i]),
        .wdata_i      (pwdata_i[7:0]),
        .count_low_o  (cnt_low[i]),
        .count_high_o (cnt_high[i]),
        .ovf_o        (ovf[i])
      );
    end
  endgenerate

  // ==========================================================
  // APB slave: ready rises in the access phase, no wait states
  // Read data is captured at the setup edge, so a count may be one
  // step older than the count at the access edge
  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    ready_nxt = setup;
    case (paddr_i)
      OFS_T0_LOW:   rdata_nxt[7:0] = cnt_low[0];
      OFS_T0_HIGH:  rdata_nxt[7:0] = cnt_high[0];
      OFS_T1_LOW:   rdata_nxt[7:0] = cnt_low[1];
      OFS_T1_HIGH:  rdata_nxt[7:0] = cnt_high[1];
      OFS_CTRL:     rdata_nxt[7:0] = {flag_r[1], run_r[1],
                                      flag_r[0], run_r[0], 4'h0};
      OFS_MODE:     rdata_nxt[7:0] = mode_r;
      OFS_CLKCTL:   rdata_nxt[7:0] = clkctl_r;
      OFS_PINCFG:   rdata_nxt[7:0] = pincfg_r;
      OFS_IRQ_EN:   rdata_nxt[1:0] = irq_en_r;
      OFS_IRQ_STAT: rdata_nxt[1:0] = stat_r;
      OFS_LINKCFG:  rdata_nxt[1:0] = link_r;
      default:      err_nxt        = setup;
    endcase
  end

  // ==========================================================
  // Control registers, flags and interrupt
  always_comb begin
    run_nxt    = run_r;
    mode_nxt   = mode_r;
    clkctl_nxt = clkctl_r;
    pincfg_nxt = pincfg_r;
    irq_en_nxt = irq_en_r;
    link_nxt   = link_r;
    // Service acknowledge clears only the control flag, not status
    flag_nxt   = flag_r & ~irq_ack_i;
    stat_nxt   = stat_r;
    if (wr_en) begin
      if (hit(paddr_i, OFS_CTRL)) begin
        // Run bits only gate stepping; counts are not cleared
        run_nxt  = {pwdata_i[CTRL_RUN1], pwdata_i[CTRL_RUN0]};
        flag_nxt = flag_nxt & {pwdata_i[CTRL_FLAG1], pwdata_i[CTRL_FLAG0]};
      end
      if (hit(paddr_i, OFS_MODE)) begin
        mode_nxt = pwdata_i[7:0];
      end
      if (hit(paddr_i, OFS_CLKCTL)) begin
        clkctl_nxt = pwdata_i[7:0];
      end
      if (hit(paddr_i, OFS_PINCFG)) begin
        pincfg_nxt = pwdata_i[7:0];
      end
      if (hit(paddr_i, OFS_IRQ_EN)) begin
        irq_en_nxt = pwdata_i[1:0];
      end
      if (hit(paddr_i, OFS_IRQ_STAT)) begin
        stat_nxt = stat_r & ~pwdata_i[1:0];
      end
      if (hit(paddr_i, OFS_LINKCFG)) begin
        link_nxt = pwdata_i[1:0];
      end
    end
    // Set wins over any clear in the same cycle
    flag_nxt = flag_nxt | ovf;
    stat_nxt = stat_nxt | ovf;
    // Registered interrupt trails status by one cycle
    irq_nxt  = |(stat_r & irq_en_r);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      run_r         <= RST_BITS;
      flag_r        <= RST_BITS;
      mode_r        <= RST_BYTE;
      clkctl_r      <= RST_BYTE;
      pincfg_r      <= RST_BYTE;
      irq_en_r      <= RST_BITS;
      stat_r        <= RST_BITS;
      link_r        <= RST_BITS;
      prdata_o      <= 32'h0000_0000;
      pready_o      <= 1'b0;
      pslverr_o     <= 1'b0;
      irq_o         <= 1'b0;
      t0_ovf_o      <= 1'b0;
      t1_ovf_o      <= 1'b0;
      ar_high_ovf_o <= 1'b0;
      adc_trig_o    <= 1'b0;
    end else begin
      run_r         <= run_nxt;
      flag_r        <= flag_nxt;
      mode_r        <= mode_nxt;
      clkctl_r      <= clkctl_nxt;
      pincfg_r      <= pincfg_nxt;
      irq_en_r      <= irq_en_nxt;
      stat_r        <= stat_nxt;
      link_r        <= link_nxt;
      prdata_o      <= rdata_nxt;
      pready_o      <= ready_nxt;
      pslverr_o     <= err_nxt;
      irq_o         <= irq_nxt;
      // Routed events are registered so every output leaves a flop
      t0_ovf_o      <= ovf[0];
      t1_ovf_o      <= ovf[1];
      ar_high_ovf_o <= link_r[LINK_SPLIT] ? ar_hi_byte_ovf_i
                                          : ar_full_ovf_i;
      // ADC source: timer 0 overflow or the auto-reload timer
      adc_trig_o    <= link_r[LINK_ADCSRC]
                       ? (link_r[LINK_SPLIT] ? ar_lo_byte_ovf_i
                                             : ar_full_ovf_i)
                       : ovf[0];
    end
  end
endmodule : timer01_mode0_counter
`default_nettype wire

// >>> rtl/timer01_pkg.sv
// Shared constants and types for the two basic timers
package timer01_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] OFS_T0_LOW   = 8'h00;
  localparam logic [7:0] OFS_T0_HIGH  = 8'h04;
  localparam logic [7:0] OFS_T1_LOW   = 8'h08;
  localparam logic [7:0] OFS_T1_HIGH  = 8'h0c;
  localparam logic [7:0] OFS_CTRL     = 8'h10;
  localparam logic [7:0] OFS_MODE     = 8'h14;
  localparam logic [7:0] OFS_CLKCTL   = 8'h18;
  localparam logic [7:0] OFS_PINCFG   = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_LINKCFG  = 8'h28;

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_RUN0   = 4;
  localparam int unsigned CTRL_FLAG0  = 5;
  localparam int unsigned CTRL_RUN1   = 6;
  localparam int unsigned CTRL_FLAG1  = 7;
  localparam int unsigned MODE_T1_LSB = 4;
  localparam int unsigned CLK_SEL0    = 2;
  localparam int unsigned CLK_SEL1    = 3;
  localparam int unsigned POL_A       = 3;
  localparam int unsigned POL_B       = 7;
  localparam int unsigned LINK_SPLIT  = 0;
  localparam int unsigned LINK_ADCSRC = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_BITS = 2'h0;

  // ==========================================================
  // Prescaler divide ratios, selected by clock_control_reg[1:0]
  localparam logic [5:0] DIV_12 = 6'h0c;
  localparam logic [5:0] DIV_4  = 6'h04;
  localparam logic [5:0] DIV_48 = 6'h30;
  localparam logic [5:0] DIV_8  = 6'h08;

  // ==========================================================
  // Mode encodings
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_8RLD   = 2'h2;
  localparam logic [1:0] MODE_HALTED = 2'h3;

  typedef struct packed {
    logic       gate;
    logic       cnt_sel;
    logic [1:0] mode;
  } timer_cfg_t;
endpackage : timer01_pkg

// >>> rtl/timer01_unit.sv
// One basic counter with its low and high count bytes
`timescale 1ns/1ps
`default_nettype none
module timer01_unit
  import timer01_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        step_i,
  input  wire timer_cfg_t  cfg_i,
  input  wire logic        wr_low_i,
  input  wire logic        wr_high_i,
  input  wire logic [7:0]  wdata_i,
  output var  logic [7:0]  count_low_o,
  output var  logic [7:0]  count_high_o,
  output var  logic        ovf_o
);
  logic [7:0]  low_r,  low_nxt;
  logic [7:0]  high_r, high_nxt;
  logic [12:0] c13;
  logic [15:0] c16;

  // ==========================================================
  // Counting
  always_comb begin
    low_nxt  = low_r;
    high_nxt = high_r;
    ovf_o    = 1'b0;
    c13      = {high_r, low_r[4:0]};
    c16      = {high_r, low_r};
    if (step_i) begin
      case (cfg_i.mode)
        MODE_13BIT: begin
          c13      = c13 + 13'h0001;
          // Upper three low bits are left alone; software masks them
          low_nxt  = {low_r[7:5], c13[4:0]};
          high_nxt = c13[12:5];
          ovf_o    = (c13 == 13'h0000);
        end
        MODE_16BIT: begin
          c16      = c16 + 16'h0001;
          {high_nxt, low_nxt} = c16;
          ovf_o    = (c16 == 16'h0000);
        end
        MODE_8RLD: begin
          low_nxt  = (low_r == 8'hff) ? high_r : low_r + 8'h01;
          ovf_o    = (low_r == 8'hff);
        end
        default: begin
          ovf_o    = 1'b0;
        end
      endcase
    end
    // A software write beats a count step in the same cycle
    if (wr_low_i) begin
      low_nxt = wdata_i;
    end
    if (wr_high_i) begin
      high_nxt = wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      low_r  <= RST_BYTE;
      high_r <= RST_BYTE;
    end else begin
      low_r  <= low_nxt;
      high_r <= high_nxt;
    end
  end

  assign count_low_o  = low_r;
  assign count_high_o = high_r;
endmodule : timer01_unit
`default_nettype wire
